// >>> rtl/cmma_top.sv
// Purpose: host access to output cells, input cells, chip selects and the muxed bus
// Assumes: one clock; product terms arrive from array logic on CLK
// Notes: host pins and clock_input_pin pass two flip-flops before use
// Functional notes
// - output cells mapped in config register space
// - host write loads every unmasked output cell
// - host load beats preset, clear, clock
// - host reads back output cell state
// - load on trailing write strobe edge
// - two eight-bit masks, reset to zero
// - mask bit one blocks host write
// - pin enable is term OR direction
// - output without enable equation always driven
// - internal node never drives its pin
// - twenty-four input cells: latch, register, pass
// - cell strobe is term or address strobe
// - strobe terms shared per four bits
// - host reads input cells
// - address strobe captures upper address bits
// - eight chip selects, polarity selectable
// - chip select enable: term or direction
// - address captured on address latch strobe
// - drive port only on addressed read
// - unused control pin two feeds array
// - cell flops rising edge, preset/clear high
`timescale 1ns/1ps
`default_nettype none
`include "cmma_map.svh"

module cmma_top (
    input wire logic CLK, // 125 mhz
    input wire logic RESET, // async, active high
    input wire logic [15:0] AD_I, // address_data_port level in
    output logic [15:0] AD_O, // address_data_port read data
    output logic AD_OE_N, // low while driving address_data_port
    input wire logic ALS, // address_latch_strobe, high = transparent
    input wire logic WR_N, // write strobe, active low
    input wire logic RD_N, // read strobe, active low
    input wire logic CNTL_TWO_I, // control_pin_two level
    input wire logic CNTL_TWO_UNUSED, // host interface leaves control_pin_two free
    output logic CNTL_TWO_TO_ARRAY, // control_pin_two as array input
    input wire logic CLOCK_INPUT_PIN, // clock_input_pin
    input wire logic [15:0] OC_PT_D, // output cell data terms
    input wire logic [15:0] OC_PT_CLK, // output cell clock terms
    input wire logic [15:0] OC_PT_PRESET, // preset terms, active high
    input wire logic [15:0] OC_PT_CLEAR, // clear terms, active high
    input wire logic [15:0] OC_CLK_SEL, // 1 = clock_input_pin clocks cell
    input wire logic [15:0] OC_COMB, // 1 = combinational cell output
    input wire logic [15:0] OC_IS_PIN, // 1 = cell declared as pin output
    input wire logic [15:0] OC_HAS_OE, // 1 = cell has enable equation
    input wire logic [15:0] OC_PT_OE, // enable terms
    input wire logic [15:0] OC_DIR, // direction register bits, ports a/b
    output logic [15:0] OC_FEEDBACK, // cell outputs back to array
    output logic [15:0] OC_PIN_O, // ports a (7:0) and b (15:8) out
    output logic [15:0] OC_PIN_OE_N, // low while cell drives its pin
    input wire logic [23:0] IC_PIN_I, // ports a, b, c pin levels
    input wire logic [47:0] IC_MODE, // two bits per input cell
    input wire logic [5:0] IC_STB_SEL, // per nibble: 1 = address strobe
    input wire logic [5:0] IC_PT_STB, // per nibble strobe terms
    output logic [23:0] IC_TO_ARRAY, // input cell outputs
    input wire logic [7:0] ECS_PT, // chip select terms
    input wire logic [7:0] ECS_ACT_LOW, // 1 = chip select active low
    input wire logic [7:0] ECS_OE_PT, // chip select enable terms
    input wire logic ECS_OE_SEL, // 1 = enable from term, 0 = direction
    input wire logic [7:0] ECS_DIR, // direction bits of chosen port
    input wire logic ECS_ON_F, // 0 = port c, 1 = port f
    output logic [7:0] ECS_C_O, // external_chip_selects on port c
    output logic [7:0] ECS_C_OE_N, // port c enable, low = drive
    output logic [7:0] ECS_F_O, // external_chip_selects on port f
    output logic [7:0] ECS_F_OE_N // port f enable, low = drive
);

    // true when the latched address names a word in the config register space
    function automatic logic reg_hit(input logic [15:0] addr, input logic [7:0] off);
        reg_hit = (addr[15:8] == `CMMA_CFG_BASE) && (addr[7:1] == off[7:1]);
    endfunction : reg_hit

    logic [`CMMA_SYNC_W-1:0] sync1_q, sync2_q;
    logic [15:0] ad_s;
    logic als_s, wr_n_s, rd_n_s, cntl_s, clock_input_pin_s;
    logic [23:0] icpin_s;
    logic wr_prev_q, clock_input_pin_prev_q;
    logic wr_rise, clock_input_pin_rise, rd_act, any_hit, hit_oc;
    logic [15:0] addr_q, addr_d;

    // two-flop synchroniser on every pin input; only stage two is read
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            sync1_q <= `CMMA_SYNC_RST;
            sync2_q <= `CMMA_SYNC_RST;
        end
        else
        begin
            sync1_q <= {AD_I, ALS, WR_N, RD_N, CNTL_TWO_I, CLOCK_INPUT_PIN, IC_PIN_I};
            sync2_q <= sync1_q;
        end
    end

    assign {ad_s, als_s, wr_n_s, rd_n_s, cntl_s, clock_input_pin_s, icpin_s} = sync2_q;
    // strobes: trailing write edge, clock pin rising edge, read level
    assign wr_rise = wr_n_s & ~wr_prev_q;
    assign clock_input_pin_rise = clock_input_pin_s & ~clock_input_pin_prev_q;
    assign rd_act = ~rd_n_s;
    assign hit_oc = reg_hit(addr_q, `CMMA_OFF_OC);
    assign any_hit = hit_oc | reg_hit(addr_q, `CMMA_OFF_MASK) | reg_hit(addr_q, `CMMA_OFF_IC_AB)
        | reg_hit(addr_q, `CMMA_OFF_IC_C);
    // address held transparent while the strobe is high, frozen at its fall
    assign addr_d = als_s ? ad_s : addr_q;

    // output cells and masks
    logic [15:0] oc_q, oc_d, out_q, out_d, ptclk_prev_q, oc_load;
    logic [7:0] mask_a_q, mask_a_d, mask_b_q, mask_b_d;

    // cell next state: host load first, then clear, preset, clock edge
    always_comb
    begin
        logic clk_edge;
        clk_edge = 1'b0;
        mask_a_d = mask_a_q;
        mask_b_d = mask_b_q;
        if (wr_rise && reg_hit(addr_q, `CMMA_OFF_MASK))
        begin
            mask_a_d = ad_s[7:0];
            mask_b_d = ad_s[15:8];
        end
        // bit n of each mask lines up with cell n of its group
        oc_load = {16{wr_rise && hit_oc}} & ~{mask_b_q, mask_a_q};
        for (int i = 0; i < 16; i++)
        begin
            clk_edge = OC_CLK_SEL[i] ? clock_input_pin_rise : (OC_PT_CLK[i] & ~ptclk_prev_q[i]);
            if (oc_load[i])
                oc_d[i] = ad_s[i];
            else if (OC_PT_CLEAR[i])
                oc_d[i] = 1'b0;
            else if (OC_PT_PRESET[i])
                oc_d[i] = 1'b1;
            else if (clk_edge)
                oc_d[i] = OC_PT_D[i];
            else
                oc_d[i] = oc_q[i];
        end
        // masked cells keep running from the array, only host writes are blocked
        out_d = (OC_COMB & OC_PT_D) | (~OC_COMB & oc_d);
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            oc_q <= 16'h0000;
            out_q <= 16'h0000;
            ptclk_prev_q <= 16'h0000;
            mask_a_q <= `CMMA_MASK_RST;
            mask_b_q <= `CMMA_MASK_RST;
            wr_prev_q <= 1'b1;
            clock_input_pin_prev_q <= 1'b0;
            addr_q <= 16'h0000;
        end
        else
        begin
            oc_q <= oc_d;
            out_q <= out_d;
            ptclk_prev_q <= OC_PT_CLK;
            mask_a_q <= mask_a_d;
            mask_b_q <= mask_b_d;
            wr_prev_q <= wr_n_s;
            clock_input_pin_prev_q <= clock_input_pin_s;
            addr_q <= addr_d;
        end
    end

    assign OC_FEEDBACK = out_q;
    assign OC_PIN_O = out_q;
    // combinational enable so a pin with no equation drives from reset on
    assign OC_PIN_OE_N = ~(OC_IS_PIN & (~OC_HAS_OE | OC_PT_OE | OC_DIR));

    // input cells
    logic [23:0] ic_q, ic_d;
    logic [5:0] stb, stb_prev_q;
    logic cntl_q, cntl_d;

    always_comb
    begin
        logic [1:0] mode;
        mode = 2'h0;
        // one strobe per four cells, from a term or from the address strobe
        stb = (IC_STB_SEL & {6{als_s}}) | (~IC_STB_SEL & IC_PT_STB);
        for (int j = 0; j < 24; j++)
        begin
            mode = IC_MODE[2*j +: 2];
            case (mode)
                cmma_pkg::CMMA_IC_PASS: ic_d[j] = icpin_s[j];
                cmma_pkg::CMMA_IC_LATCH: ic_d[j] = stb[j/4] ? icpin_s[j] : ic_q[j];
                cmma_pkg::CMMA_IC_REG: ic_d[j] = (stb[j/4] & ~stb_prev_q[j/4]) ? icpin_s[j] : ic_q[j];
                default: ic_d[j] = ic_q[j];
            endcase
        end
        cntl_d = cntl_s & CNTL_TWO_UNUSED;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ic_q <= 24'h000000;
            stb_prev_q <= 6'h00;
            cntl_q <= 1'b0;
        end
        else
        begin
            ic_q <= ic_d;
            stb_prev_q <= stb;
            cntl_q <= cntl_d;
        end
    end

    assign IC_TO_ARRAY = ic_q;
    assign CNTL_TWO_TO_ARRAY = cntl_q;

    // host read path
    cmma_pkg::cmma_bus_state_t bus_q, bus_d;
    logic [15:0] rdata_q, rdata_d;

    // read data follows the addressed register for the whole read strobe
    always_comb
    begin
        bus_d = bus_q;
        rdata_d = rdata_q;
        if (rd_act && any_hit)
        begin
            if (hit_oc)
                rdata_d = oc_q;
            else if (reg_hit(addr_q, `CMMA_OFF_MASK))
                rdata_d = {mask_b_q, mask_a_q};
            else if (reg_hit(addr_q, `CMMA_OFF_IC_AB))
                rdata_d = ic_q[15:0];
            else
                rdata_d = {8'h00, ic_q[23:16]};
        end
        case (bus_q)
            cmma_pkg::CMMA_BUS_IDLE: if (rd_act && any_hit) bus_d = cmma_pkg::CMMA_BUS_READ;
            cmma_pkg::CMMA_BUS_READ: if (!(rd_act && any_hit)) bus_d = cmma_pkg::CMMA_BUS_IDLE;
            default: bus_d = cmma_pkg::CMMA_BUS_IDLE;
        endcase
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            bus_q <= cmma_pkg::CMMA_BUS_IDLE;
            rdata_q <= 16'h0000;
        end
        else
        begin
            bus_q <= bus_d;
            rdata_q <= rdata_d;
        end
    end

    assign AD_O = rdata_q;
    // released the cycle the strobe or the hit goes, so bus contention stays short
    assign AD_OE_N = ~((bus_q == cmma_pkg::CMMA_BUS_READ) && rd_act && any_hit);

    // external chip selects
    logic [7:0] ecs_q, ecs_d, ecs_oe;

    // polarity applied here, routed to one of two ports
    always_comb
    begin
        ecs_d = ECS_PT ^ ECS_ACT_LOW;
        ecs_oe = ECS_OE_SEL ? ECS_OE_PT : ECS_DIR;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            ecs_q <= 8'h00;
        else
            ecs_q <= ecs_d;
    end

    assign ECS_C_O = ecs_q;
    assign ECS_F_O = ecs_q;
    assign ECS_C_OE_N = ~(ecs_oe & {8{~ECS_ON_F}});
    assign ECS_F_OE_N = ~(ecs_oe & {8{ECS_ON_F}});

    // checks
    a_load_takes_data: assert property (@(posedge CLK) disable iff (RESET)
        (|oc_load) |=> ((oc_q & $past(oc_load)) == ($past(ad_s) & $past(oc_load))))
        else $error("host load did not land in output cells");
    a_mask_blocks_load: assert property (@(posedge CLK) disable iff (RESET)
        (wr_rise && hit_oc) |=> (((oc_q ^ $past(oc_q)) & {$past(mask_b_q), $past(mask_a_q)} & ~$past(OC_PT_CLEAR)
        & ~$past(OC_PT_PRESET) & ~$past(OC_PT_CLK) & ~{16{$past(clock_input_pin_rise)}}) == 16'h0000))
        else $error("masked output cell was loaded");
    a_mask_reset_value: assert property (@(posedge CLK) disable iff (RESET)
        $past(RESET) |-> ({mask_b_q, mask_a_q} == 16'h0000))
        else $error("mask not zero after reset");
    a_load_on_trailing: assert property (@(posedge CLK) disable iff (RESET)
        (|oc_load) |-> ($rose(wr_n_s) && hit_oc))
        else $error("load away from trailing write edge");
    a_port_drive_read: assert property (@(posedge CLK) disable iff (RESET)
        !AD_OE_N |-> (rd_act && any_hit && $past(rd_act)))
        else $error("port driven outside addressed read");
    a_readback_cells: assert property (@(posedge CLK) disable iff (RESET)
        (rd_act && hit_oc) |=> (AD_O == $past(oc_q)))
        else $error("read back differs from output cells");
    a_address_capture: assert property (@(posedge CLK) disable iff (RESET)
        $fell(als_s) |-> (addr_q == $past(ad_s)))
        else $error("address not captured on strobe");
    a_node_pin_quiet: assert property (@(posedge CLK) disable iff (RESET)
        ((~OC_PIN_OE_N & ~OC_IS_PIN) == 16'h0000) && ((OC_IS_PIN & (OC_PT_OE | OC_DIR) & OC_PIN_OE_N) == 16'h0000))
        else $error("output cell pin enable wrong");
    a_ecs_polarity: assert property (@(posedge CLK) disable iff (RESET)
        1'b1 |=> (ECS_C_O == ($past(ECS_PT) ^ $past(ECS_ACT_LOW))))
        else $error("chip select polarity wrong");

endmodule : cmma_top

`default_nettype wire

// >>> rtl/cmma_map.svh
// Purpose: address map, reset values and pin-vector layout for the macrocell access block
// Assumes: 16-bit multiplexed host bus, config register space at one 256-byte page
// Notes: offsets are byte addresses inside the config register space page
`ifndef CMMA_MAP_SVH
`define CMMA_MAP_SVH

// page of the config register space (address bits 15:8)
`define CMMA_CFG_BASE 8'hff
// output cells, group a on d7-0, group b on d15-8
`define CMMA_OFF_OC 8'h20
// mask registers, group a on d7-0, group b on d15-8
`define CMMA_OFF_MASK 8'h22
// input cells of ports a (d7-0) and b (d15-8)
`define CMMA_OFF_IC_AB 8'h18
// input cells of port c (d7-0), upper byte reads zero
`define CMMA_OFF_IC_C 8'h1a
`define CMMA_MASK_RST 8'h00
// synchroniser reset: write and read strobes idle high so no false trailing edge after reset
`define CMMA_SYNC_RST 45'h000_0c00_0000
`define CMMA_SYNC_W 45

`endif

// >>> rtl/cmma_pkg.sv
// Purpose: shared types of the macrocell access block
// Assumes: used with cmma_map.svh
// Notes: bus state is one-hot
package cmma_pkg;

    // input cell behaviour, two bits per cell
    typedef enum logic [1:0] {
        CMMA_IC_PASS = 2'h0,
        CMMA_IC_LATCH = 2'h1,
        CMMA_IC_REG = 2'h2
    } cmma_ic_mode_t;

    // host read state
    typedef enum logic [1:0] {
        CMMA_BUS_IDLE = 2'h1,
        CMMA_BUS_READ = 2'h2
    } cmma_bus_state_t;

endpackage : cmma_pkg

// >>> test/cmma_host_model.sv
// Purpose: host controller model on the multiplexed address/data bus
// Assumes: strobes change on the falling clock edge, each level held several cycles
// Notes: a released bus shows the inverse of the last driven word, never a stale copy
`timescale 1ns/1ps
`default_nettype none

module cmma_host_model (
    input wire logic clk, // bus clock
    input wire logic [15:0] ad_o, // device read data
    input wire logic ad_oe_n, // low while the device drives
    output logic [15:0] ad_i, // resolved address_data_port level
    output var logic als, // address_latch_strobe
    output var logic wr_n, // write strobe
    output var logic rd_n // read strobe
);
    logic [15:0] drv_q;
    logic drv_en;

    // wire level from both parties' enables
    assign ad_i = drv_en ? drv_q : (!ad_oe_n ? ad_o : ~drv_q);

    // idle bus at time zero
    initial
    begin
        {als, drv_en, drv_q} = '0;
        {wr_n, rd_n} = 2'h3;
    end

    // address phase: strobe pulse with the address held on the port
    task automatic addr(input logic [15:0] a);
        @(negedge clk);
        drv_en = 1'b1;
        drv_q = a;
        als = 1'b1;
        repeat (3) @(negedge clk);
        als = 1'b0;
    endtask : addr

    // data held three cycles past the trailing strobe edge for the synchroniser
    task automatic write(input logic [15:0] a, input logic [15:0] d);
        addr(a);
        @(negedge clk);
        drv_q = d;
        wr_n = 1'b0;
        repeat (4) @(negedge clk);
        wr_n = 1'b1;
        repeat (3) @(negedge clk);
        drv_en = 1'b0;
        repeat (3) @(negedge clk);
    endtask : write

    // read: port released, data taken while the device drives
    task automatic read(input logic [15:0] a, output logic [15:0] d, output logic hit);
        addr(a);
        @(negedge clk);
        drv_en = 1'b0;
        rd_n = 1'b0;
        hit = 1'b0;
        d = '0;
        repeat (6)
        begin
            @(negedge clk);
            if (ad_oe_n === 1'b0)
            begin
                hit = 1'b1;
                d = ad_o;
            end
        end
        rd_n = 1'b1;
        repeat (5) @(negedge clk);
    endtask : read

endmodule : cmma_host_model

`default_nettype wire

// >>> test/tb.sv
// Purpose: self-checking bench for the macrocell access block
// Assumes: host model on the muxed bus, array terms and config driven here
// Notes: expected values are worked out by hand from the documented behaviour
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic CLK, RESET, ALS, WR_N, RD_N, AD_OE_N, CNTL_TWO_I, CNTL_TWO_UNUSED, CNTL_TWO_TO_ARRAY, CLOCK_INPUT_PIN;
    logic [15:0] AD_I, AD_O, OC_PT_D, OC_PT_CLK, OC_PT_PRESET, OC_PT_CLEAR, OC_CLK_SEL, OC_COMB, OC_IS_PIN;
    logic [15:0] OC_HAS_OE, OC_PT_OE, OC_DIR, OC_FEEDBACK, OC_PIN_O, OC_PIN_OE_N;
    logic [23:0] IC_PIN_I, IC_TO_ARRAY;
    logic [47:0] IC_MODE;
    logic [5:0] IC_STB_SEL, IC_PT_STB;
    logic [7:0] ECS_PT, ECS_ACT_LOW, ECS_OE_PT, ECS_DIR, ECS_C_O, ECS_C_OE_N, ECS_F_O, ECS_F_OE_N;
    logic ECS_OE_SEL, ECS_ON_F;
    int failures = 0;
    int checks_done = 0;

    cmma_top dut (.CLK(CLK), .RESET(RESET), .AD_I(AD_I), .AD_O(AD_O), .AD_OE_N(AD_OE_N), .ALS(ALS),
        .WR_N(WR_N), .RD_N(RD_N), .CNTL_TWO_I(CNTL_TWO_I), .CNTL_TWO_UNUSED(CNTL_TWO_UNUSED),
        .CNTL_TWO_TO_ARRAY(CNTL_TWO_TO_ARRAY), .CLOCK_INPUT_PIN(CLOCK_INPUT_PIN), .OC_PT_D(OC_PT_D),
        .OC_PT_CLK(OC_PT_CLK), .OC_PT_PRESET(OC_PT_PRESET), .OC_PT_CLEAR(OC_PT_CLEAR), .OC_CLK_SEL(OC_CLK_SEL),
        .OC_COMB(OC_COMB), .OC_IS_PIN(OC_IS_PIN), .OC_HAS_OE(OC_HAS_OE), .OC_PT_OE(OC_PT_OE), .OC_DIR(OC_DIR),
        .OC_FEEDBACK(OC_FEEDBACK), .OC_PIN_O(OC_PIN_O), .OC_PIN_OE_N(OC_PIN_OE_N), .IC_PIN_I(IC_PIN_I),
        .IC_MODE(IC_MODE), .IC_STB_SEL(IC_STB_SEL), .IC_PT_STB(IC_PT_STB), .IC_TO_ARRAY(IC_TO_ARRAY),
        .ECS_PT(ECS_PT), .ECS_ACT_LOW(ECS_ACT_LOW), .ECS_OE_PT(ECS_OE_PT), .ECS_OE_SEL(ECS_OE_SEL),
        .ECS_DIR(ECS_DIR), .ECS_ON_F(ECS_ON_F), .ECS_C_O(ECS_C_O), .ECS_C_OE_N(ECS_C_OE_N), .ECS_F_O(ECS_F_O),
        .ECS_F_OE_N(ECS_F_OE_N));
    cmma_host_model host (.clk(CLK), .ad_o(AD_O), .ad_oe_n(AD_OE_N), .ad_i(AD_I), .als(ALS), .wr_n(WR_N),
        .rd_n(RD_N));

    // 125 mhz clock
    initial
    begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    task automatic cyc(input int n);
        repeat (n) @(negedge CLK);
    endtask : cyc

    // read a word; hit flag joins the data so a miss passes only where one is expected
    task automatic rd_chk(input logic [15:0] a, input logic hit_exp, input logic [15:0] exp);
        logic [15:0] d;
        logic hit;
        host.read(a, d, hit);
        check({hit, d}, {hit_exp, exp});
    endtask : rd_chk

    task automatic t_load;
        rd_chk(16'hff22, 1'b1, 16'h0000);
        fork
            host.write(16'hff20, 16'ha55a);
            begin
                cyc(8);
                check(OC_FEEDBACK, 16'h0000);
            end
        join
        check(OC_PIN_O, 16'ha55a);
        rd_chk(16'hff20, 1'b1, 16'ha55a);
    endtask : t_load

    // masked bits keep their value on a host write; clear and preset terms still act on them
    task automatic t_mask;
        logic seen;
        seen = 1'b0;
        host.write(16'hff22, 16'hf00f);
        rd_chk(16'hff22, 1'b1, 16'hf00f);
        host.write(16'hff20, 16'h0ff0);
        check(OC_FEEDBACK, 16'haffa);
        OC_PT_CLEAR = 16'h0002;
        cyc(1);
        OC_PT_CLEAR = 16'h0000;
        OC_PT_PRESET = 16'h0004;
        cyc(1);
        OC_PT_PRESET = 16'h0000;
        cyc(2);
        check(OC_FEEDBACK, 16'haffc);
        OC_PT_CLK = 16'h0010;
        OC_CLK_SEL = 16'h0020;
        CLOCK_INPUT_PIN = 1'b1;
        cyc(5);
        {OC_PT_CLK, CLOCK_INPUT_PIN} = '0;
        cyc(2);
        check(OC_FEEDBACK, 16'hafcc);
        host.write(16'hff22, 16'h0000);
        // preset held high: the host load must still show for the one cycle it wins
        OC_PT_PRESET = 16'hffff;
        fork
            host.write(16'hff20, 16'h1234);
            repeat (20)
            begin
                @(negedge CLK);
                if (OC_FEEDBACK === 16'h1234)
                    seen = 1'b1;
            end
        join
        OC_PT_PRESET = 16'h0000;
        check(seen, 1'b1);
    endtask : t_mask

    task automatic t_input;
        IC_PIN_I = 24'h5a3c96;
        cyc(4);
        check(IC_TO_ARRAY, 24'h5a3c96);
        rd_chk(16'hff18, 1'b1, 16'h3c96);
        rd_chk(16'hff1a, 1'b1, 16'h005a);
        IC_MODE[15:0] = 16'h55aa;
        IC_STB_SEL = 6'h01;
        IC_PIN_I[7:0] = 8'h36;
        IC_PT_STB = 6'h02;
        rd_chk(16'hff40, 1'b0, 16'h0000);
        IC_PT_STB = 6'h00;
        cyc(3);
        IC_PIN_I[7:0] = 8'hc9;
        cyc(4);
        check(IC_TO_ARRAY[7:0], 8'h36);
    endtask : t_input

    task automatic t_pins;
        rd_chk(16'h0020, 1'b0, 16'h0000);
        check(AD_OE_N, 1'b1);
        {OC_IS_PIN, OC_HAS_OE, OC_PT_OE, OC_DIR} = {16'h00ff, 16'h0f0f, 16'h0303, 16'h0505};
        cyc(1);
        check(OC_PIN_OE_N, 16'hff08);
        // combinational cells pass the data term straight to feedback and pin
        {OC_COMB, OC_PT_D} = {16'hffff, 16'h6c39};
        cyc(2);
        check(OC_FEEDBACK, 16'h6c39);
        {ECS_PT, ECS_ACT_LOW, ECS_OE_PT, ECS_OE_SEL, ECS_ON_F} = {8'h0f, 8'h33, 8'h55, 1'b1, 1'b0};
        cyc(3);
        check({ECS_C_O, ECS_C_OE_N, ECS_F_OE_N}, {8'h3c, 8'haa, 8'hff});
        {ECS_OE_SEL, ECS_ON_F, ECS_DIR} = {1'b0, 1'b1, 8'ha0};
        cyc(3);
        check({ECS_F_O, ECS_C_OE_N, ECS_F_OE_N}, {8'h3c, 8'hff, 8'h5f});
        {CNTL_TWO_UNUSED, CNTL_TWO_I} = 2'h3;
        cyc(4);
        check(CNTL_TWO_TO_ARRAY, 1'b1);
        CNTL_TWO_UNUSED = 1'b0;
        cyc(4);
        check(CNTL_TWO_TO_ARRAY, 1'b0);
    endtask : t_pins

    // reset, scenarios, verdict
    initial
    begin
        RESET = 1'b1;
        {OC_PT_D, OC_PT_CLK, OC_PT_PRESET, OC_PT_CLEAR, OC_CLK_SEL, OC_COMB, OC_IS_PIN} = '0;
        {OC_HAS_OE, OC_PT_OE, OC_DIR, IC_PIN_I, IC_MODE, IC_STB_SEL, IC_PT_STB} = '0;
        {ECS_PT, ECS_ACT_LOW, ECS_OE_PT, ECS_DIR, ECS_OE_SEL, ECS_ON_F} = '0;
        {CNTL_TWO_I, CNTL_TWO_UNUSED, CLOCK_INPUT_PIN} = '0;
        cyc(6);
        RESET = 1'b0;
        cyc(3);
        t_load();
        t_mask();
        t_input();
        t_pins();
        end_sim();
    end

endmodule : tb

`default_nettype wire
